// ---- cursor_plane_control.sv ----
// cursor plane control register bank for three pipes
`timescale 1ns/1ps
`default_nettype none
module cursor_plane_control
    import cursor_plane_pkg::*;
#(
    parameter int PIPES = NUM_PIPES
)
(
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  mmio_wr,
    input  wire logic                  mmio_rd,
    input  wire logic [ADDR_W-1:0]     mmio_addr,
    input  wire logic [DATA_W-1:0]     mmio_wdata,
    output logic      [DATA_W-1:0]     mmio_rdata,
    output logic                       mmio_rvalid,
    input  wire logic [PIPES-1:0]      vblank_start,
    input  wire logic [PIPES-1:0]      pipe_enable,
    output logic      [PIPES-1:0]      cursor_enable,
    output logic      [PIPES-1:0]      gamma_select,
    output logic      [PIPES-1:0]      color_space_conversion_bypass_select,
    output logic      [PIPES-1:0]      rotate_180,
    output logic      [PIPES*4-1:0]    cursor_mode,
    output logic      [PIPES*20-1:0]   cursor_base_address,
    output logic      [PIPES-1:0]      rotate_format_error
);
    // elaboration check: only three register sets exist in the map
    if (PIPES < 1 || PIPES > NUM_PIPES)
    begin : bad_pipes_g
        $error("PIPES must be 1 to 3");
    end

    localparam logic [19:0] CTL_ADDRS  [3] = '{CTL_ONE_ADDR, CTL_TWO_ADDR, CTL_THREE_ADDR};
    localparam logic [19:0] BASE_ADDRS [3] = '{BASE_ONE_ADDR, BASE_TWO_ADDR, BASE_THREE_ADDR};

    logic [31:0] pending  [PIPES];
    logic [31:0] active   [PIPES];
    logic [31:0] base_pnd [PIPES];
    logic [31:0] base_act [PIPES];
    logic [PIPES-1:0] ctl_hit;
    logic [PIPES-1:0] base_hit;
    logic [31:0] rd_mux   [PIPES+1];
    logic [31:0] rdata_next;

    genvar g;
    generate
        for (g = 0; g < PIPES; g++)
        begin : pipe_g
            logic [3:0] mode_a;
            // address decode for this pipe
            assign ctl_hit[g]  = (mmio_addr == CTL_ADDRS[g]);
            assign base_hit[g] = (mmio_addr == BASE_ADDRS[g]);
            assign mode_a      = mode_sel(active[g]);

            cursor_ctl_slot u_slot (
                .clk              (clk),
                .rstn             (rstn),
                .ctl_wr           (mmio_wr && ctl_hit[g]),
                .base_wr          (mmio_wr && base_hit[g]),
                .wdata            (mmio_wdata),
                .vblank_start     (vblank_start[g]),
                .pipe_enable      (pipe_enable[g]),
                .pending_reg      (pending[g]),
                .active_reg       (active[g]),
                .base_pending_reg (base_pnd[g]),
                .base_active_reg  (base_act[g]),
                .armed_reg        ()
            );

            // read data: pending copy is what software sees
            assign rd_mux[g+1] = rd_mux[g]
                               | (ctl_hit[g]  ? pending[g]  : 32'h0000_0000)
                               | (base_hit[g] ? base_pnd[g] : 32'h0000_0000);

            // decoded plane controls from the active copy
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    cursor_enable[g]                        <= 1'b0;
                    gamma_select[g]                         <= 1'b0;
                    color_space_conversion_bypass_select[g] <= 1'b0;
                    rotate_180[g]                           <= 1'b0;
                    cursor_mode[g*4 +: 4]                   <= MODE_OFF;
                    cursor_base_address[g*20 +: 20]         <= 20'h00000;
                    rotate_format_error[g]                  <= 1'b0;
                end
                else
                begin
                    cursor_enable[g]                        <= mode_valid(mode_a);
                    gamma_select[g]                         <= active[g][GAMMA_BIT];
                    color_space_conversion_bypass_select[g] <= active[g][CSC_BIT];
                    rotate_180[g]                           <= active[g][ROTATE_BIT];
                    cursor_mode[g*4 +: 4]                   <= mode_a;
                    cursor_base_address[g*20 +: 20]         <= base_act[g][31:12];
                    rotate_format_error[g]                  <= active[g][ROTATE_BIT]
                                                               && mode_2bpp(mode_a);
                end
            end
        end
    endgenerate

    assign rd_mux[0]  = 32'h0000_0000;
    assign rdata_next = mmio_rd ? rd_mux[PIPES] : 32'h0000_0000;

    // registered read answer one cycle after the request
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mmio_rdata  <= 32'h0000_0000;
            mmio_rvalid <= 1'b0;
        end
        else
        begin
            mmio_rdata  <= rdata_next;
            mmio_rvalid <= mmio_rd;
        end
    end
endmodule
`default_nettype wire

// ---- cursor_plane_pkg.sv ----
// package with register map, field layout and mode decoding for the cursor plane control
package cursor_plane_pkg;
    localparam int          ADDR_W          = 20;
    localparam int          DATA_W          = 32;
    localparam int          NUM_PIPES       = 3;
    // register byte addresses, one control and one base for each pipe
    localparam logic [19:0] CTL_ONE_ADDR    = 20'h70080;
    localparam logic [19:0] CTL_TWO_ADDR    = 20'h71080;
    localparam logic [19:0] CTL_THREE_ADDR  = 20'h72080;
    localparam logic [19:0] BASE_ONE_ADDR   = 20'h70084;
    localparam logic [19:0] BASE_TWO_ADDR   = 20'h71084;
    localparam logic [19:0] BASE_THREE_ADDR = 20'h72084;
    // control field positions
    localparam int          GAMMA_BIT       = 26;
    localparam int          CSC_BIT         = 24;
    localparam int          ROTATE_BIT      = 15;
    localparam int          MODE_HI_BIT     = 5;
    localparam int          MODE_LO_MSB     = 2;
    // writable bits of the control word, everything else reads zero
    localparam logic [31:0] CTL_WMASK       = 32'h0500_8027;
    // base keeps address bits 31:12 only
    localparam logic [31:0] BASE_WMASK      = 32'hffff_f000;
    localparam logic [31:0] CTL_RESET       = 32'h0000_0000;
    localparam logic [31:0] BASE_RESET      = 32'h0000_0000;
    localparam logic [3:0]  MODE_OFF        = 4'h0;
    localparam logic [3:0]  MODE_RSVD_A     = 4'h1;
    localparam logic [3:0]  MODE_RSVD_B     = 4'h8;
    localparam logic [3:0]  MODE_RSVD_C     = 4'h9;
    localparam logic [3:0]  MODE_2BPP_LO    = 4'h4;
    localparam logic [3:0]  MODE_2BPP_HI    = 4'h6;

    // four bit mode selection from bit 5 and bits 2:0
    function automatic logic [3:0] mode_sel(input logic [31:0] ctl);
        mode_sel = {ctl[MODE_HI_BIT], ctl[MODE_LO_MSB:0]};
    endfunction

    // valid non reserved mode means the cursor is on
    function automatic logic mode_valid(input logic [3:0] m);
        mode_valid = (m != MODE_OFF) && (m != MODE_RSVD_A)
                  && (m != MODE_RSVD_B) && (m != MODE_RSVD_C);
    endfunction

    // indexed two bit per pixel formats cannot be rotated
    function automatic logic mode_2bpp(input logic [3:0] m);
        mode_2bpp = (m >= MODE_2BPP_LO) && (m <= MODE_2BPP_HI);
    endfunction
endpackage

// ---- cursor_ctl_slot.sv ----
// one pipe's pending and active cursor control copies with arming
`timescale 1ns/1ps
`default_nettype none
module cursor_ctl_slot
    import cursor_plane_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ctl_wr,
    input  wire logic        base_wr,
    input  wire logic [31:0] wdata,
    input  wire logic        vblank_start,
    input  wire logic        pipe_enable,
    output logic      [31:0] pending_reg,
    output logic      [31:0] active_reg,
    output logic      [31:0] base_pending_reg,
    output logic      [31:0] base_active_reg,
    output logic             armed_reg
);
    logic [31:0] pending_next;
    logic [31:0] base_pending_next;
    logic        cursor_off;
    logic        update_point;
    logic        commit;
    logic        armed_next;

    // update point: vblank, pipe off, or cursor not enabled
    assign cursor_off        = !mode_valid(mode_sel(active_reg));
    assign update_point      = vblank_start || !pipe_enable || cursor_off;
    assign commit            = (armed_reg || base_wr) && update_point;
    assign pending_next      = ctl_wr ? (wdata & CTL_WMASK) : pending_reg;
    assign base_pending_next = base_wr ? (wdata & BASE_WMASK) : base_pending_reg;
    // a base write at an update point commits in that same edge and leaves the arm flag clear
    assign armed_next        = base_wr ? !update_point : (armed_reg && !commit);

    // pending copies and arm flag
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pending_reg      <= CTL_RESET;
            base_pending_reg <= BASE_RESET;
            armed_reg        <= 1'b0;
        end
        else
        begin
            pending_reg      <= pending_next;
            base_pending_reg <= base_pending_next;
            armed_reg        <= armed_next;
        end
    end

    // control and base move to active together in one edge
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            active_reg      <= CTL_RESET;
            base_active_reg <= BASE_RESET;
        end
        else if (commit)
        begin
            active_reg      <= pending_next;
            base_active_reg <= base_pending_next;
        end
    end
endmodule
`default_nettype wire

// ---- cursor_plane_checker.sv ----
// concurrent checks on pipe 0 outputs and the register read port
`timescale 1ns/1ps
`default_nettype none
module cursor_plane_checker
    import cursor_plane_pkg::*;
#(
    parameter int PIPES = NUM_PIPES
)
(
    input wire logic               clk,
    input wire logic               rstn,
    input wire logic               mmio_rd,
    input wire logic [DATA_W-1:0]  mmio_rdata,
    input wire logic               mmio_rvalid,
    input wire logic [PIPES-1:0]   vblank_start,
    input wire logic [PIPES-1:0]   pipe_enable,
    input wire logic [PIPES-1:0]   cursor_enable,
    input wire logic [PIPES-1:0]   gamma_select,
    input wire logic [PIPES-1:0]   rotate_180,
    input wire logic [PIPES*4-1:0] cursor_mode,
    input wire logic [PIPES*20-1:0] cursor_base_address,
    input wire logic [PIPES-1:0]   rotate_format_error
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // no update point at the edge, and the old active mode was on
    sequence s_hold;
        !vblank_start[0] && pipe_enable[0] ##1 cursor_enable[0];
    endsequence
    property p_rvalid; mmio_rd |=> mmio_rvalid; endproperty
    property p_idle; !mmio_rvalid |-> mmio_rdata == 32'h0; endproperty
    property p_rsvd; mmio_rvalid |-> (mmio_rdata & 32'h0000_0fd8) == 32'h0; endproperty
    property p_enable;
        cursor_enable[0] == !(cursor_mode[3:0] inside {4'h0, 4'h1, 4'h8, 4'h9});
    endproperty
    property p_off; cursor_mode[3:0] == 4'h0 |-> !cursor_enable[0]; endproperty
    property p_hold_rot; s_hold |=> $stable(rotate_180[0]); endproperty
    property p_hold_base;
        s_hold |=> $stable(cursor_base_address[19:0]) && $stable(gamma_select[0]);
    endproperty
    property p_hold_mode; s_hold |=> $stable(cursor_mode[3:0]); endproperty
    property p_fmt;
        rotate_format_error[0] == (rotate_180[0] && cursor_mode[3:0] inside {[4'h4:4'h6]});
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    a_idle: assert property (p_idle) else $error("read data not idle zero");
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
    a_enable: assert property (p_enable) else $error("enable mismatches mode");
    a_off: assert property (p_off) else $error("cursor on with zero mode");
    a_hold_rot: assert property (p_hold_rot) else $error("rotation moved off update");
    a_hold_base: assert property (p_hold_base) else $error("base moved off update");
    a_hold_mode: assert property (p_hold_mode) else $error("mode moved off update");
    a_fmt: assert property (p_fmt) else $error("format flag wrong");
endmodule
bind cursor_plane_control cursor_plane_checker #(.PIPES(PIPES)) u_chk (.clk(clk), .rstn(rstn),
    .mmio_rd(mmio_rd), .mmio_rdata(mmio_rdata), .mmio_rvalid(mmio_rvalid),
    .vblank_start(vblank_start), .pipe_enable(pipe_enable), .cursor_enable(cursor_enable),
    .gamma_select(gamma_select), .rotate_180(rotate_180), .cursor_mode(cursor_mode),
    .cursor_base_address(cursor_base_address), .rotate_format_error(rotate_format_error));
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the cursor plane control bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cursor_plane_pkg::*;
    logic        clk, rstn, mmio_wr, mmio_rd, mmio_rvalid;
    logic [19:0] mmio_addr;
    logic [31:0] mmio_wdata, mmio_rdata, rnd, c0, b0, c1, b1;
    logic [2:0]  vblank_start, pipe_enable, cursor_enable, gamma_select, rotate_180;
    logic [2:0]  color_space_conversion_bypass_select, rotate_format_error;
    logic [11:0] cursor_mode;
    logic [59:0] cursor_base_address;
    int          err_count, total_checks, q;
    cursor_plane_control #(.PIPES(3)) u_dut (.clk(clk), .rstn(rstn), .mmio_wr(mmio_wr),
        .mmio_rd(mmio_rd), .mmio_addr(mmio_addr), .mmio_wdata(mmio_wdata),
        .mmio_rdata(mmio_rdata), .mmio_rvalid(mmio_rvalid), .vblank_start(vblank_start),
        .pipe_enable(pipe_enable), .cursor_enable(cursor_enable), .gamma_select(gamma_select),
        .color_space_conversion_bypass_select(color_space_conversion_bypass_select),
        .rotate_180(rotate_180), .cursor_mode(cursor_mode),
        .cursor_base_address(cursor_base_address), .rotate_format_error(rotate_format_error));
    // free running clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [19:0] adr(input int p, input logic base);
        adr = CTL_ONE_ADDR + 20'h01000 * p[19:0] + (base ? 20'h00004 : 20'h00000);
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        @(posedge clk);
        mmio_wr <= 1'b1;
        mmio_addr <= a;
        mmio_wdata <= d;
        @(posedge clk);
        mmio_wr <= 1'b0;
    endtask
    task automatic rd(input logic [19:0] a, input logic [31:0] e);
        @(posedge clk);
        mmio_rd <= 1'b1;
        mmio_addr <= a;
        @(posedge clk);
        mmio_rd <= 1'b0;
        #1;
        chk("rdata", e, mmio_rdata);
        chk("rvalid", 32'h1, {31'h0, mmio_rvalid});
    endtask
    // one cycle vertical blank pulse on the selected pipes
    task automatic pulse(input logic [2:0] v);
        @(posedge clk);
        vblank_start <= v;
        @(posedge clk);
        vblank_start <= 3'b000;
    endtask
    // compare one pipe's decoded outputs with an expected active pair
    task automatic outs(input int p, input logic [31:0] c, input logic [31:0] b);
        logic [3:0] m;
        m = {c[5], c[2:0]};
        repeat (3) @(posedge clk);
        #1;
        chk("gamma", {31'h0, c[26]}, {31'h0, gamma_select[p]});
        chk("csc", {31'h0, c[24]}, {31'h0, color_space_conversion_bypass_select[p]});
        chk("rotate", {31'h0, c[15]}, {31'h0, rotate_180[p]});
        chk("mode", {28'h0, m}, {28'h0, cursor_mode[p*4+:4]});
        chk("enable", {31'h0, !(m inside {4'h0, 4'h1, 4'h8, 4'h9})}, {31'h0, cursor_enable[p]});
        chk("base", {12'h0, b[31:12]}, {12'h0, cursor_base_address[p*20+:20]});
        chk("fmt", 32'h0, {31'h0, rotate_format_error[p]});
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog against a hung sequence
    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        stop_test();
    end
    // main sequence
    initial
    begin
        {rstn, mmio_wr, mmio_rd, mmio_addr, mmio_wdata, vblank_start} = '0;
        {err_count, total_checks, pipe_enable, rnd} = {64'h0, 3'h7, 32'h0000_0044};
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        for (q = 0; q < 3; q++)
        begin
            rd(adr(q, 1'b0), 32'h0);
            rnd = lfsr(rnd);
            c0 = (rnd & ~32'h0000_0027) | 32'h0000_0007; // 32 bpp mode keeps rotation legal
            b0 = lfsr(rnd);
            wr(adr(q, 1'b0), c0);
            outs(q, 32'h0, 32'h0);
            rd(adr(q, 1'b0), c0 & CTL_WMASK);
            wr(adr(q, 1'b1), b0);
            rd(adr(q, 1'b1), b0 & BASE_WMASK);
            outs(q, c0 & CTL_WMASK, b0);
            if (q == 0) {c1, b1} = {c0 & CTL_WMASK, b0};
        end
        // pipe 0 now shows a cursor, so only vblank of pipe 0 may commit
        // rotation may be asked here; the screen position lives outside this bank
        c0 = (lfsr(rnd) & ~32'h0000_0027) | 32'h0000_0007;
        wr(adr(0, 1'b0), c0);
        wr(adr(0, 1'b1), rnd);
        outs(0, c1, b1);
        pulse(3'b110);
        outs(0, c1, b1);
        pulse(3'b001);
        outs(0, c0 & CTL_WMASK, rnd);
        c1 = (lfsr(c0) & CTL_WMASK) | 32'h0000_0027;
        b1 = lfsr(c1);
        wr(adr(0, 1'b0), c1);
        wr(adr(0, 1'b1), b1);
        outs(0, c0 & CTL_WMASK, rnd);
        pulse(3'b001);
        outs(0, c1, b1);
        // control write with no base write stays pending through vblank
        wr(adr(0, 1'b0), c0);
        pulse(3'b001);
        outs(0, c1, b1);
        @(posedge clk);
        pipe_enable <= 3'b000;
        for (q = 0; q < 16; q++)
        begin
            rnd = lfsr(rnd);
            c1 = (rnd & ((q inside {4, 5, 6}) ? 32'h0500_0000 : 32'h0500_8000))
               | {26'h0, q[3], 2'b00, q[2:0]}; // rotation kept off for 2 bpp
            wr(adr(q % 3, 1'b0), c1);
            wr(adr(q % 3, 1'b1), rnd);
            outs(q % 3, c1, rnd);
        end
        rd(20'h70088, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
